/* File: rtl/acr_config_bank.sv */
// adc configuration register bank with waveform debug registers
// ============================================================================
// Functional notes
// - writing d6 to soft reset restores defaults
// - normal mode loads adc results into waveforms
// - static mode freezes waveforms except host writes
// - count mode allows writes, increments per sample
// - reserved mode code behaves as normal
// - crc check enable bit resets to one
// - bit0 picks clock out versus sample ready
// - filter bits 6,5,4 invert v2,v1,current
// - filter bit3 picks 2.7 or 3.3 kHz
// - filter bits 2:0 pick sinc3 chain, rate
`default_nettype none
module acr_config_bank (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // register port from the serial interface
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [acr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [acr_pkg::DATA_W-1:0]  reg_wdata,
  output logic [acr_pkg::DATA_W-1:0]       reg_rdata,
  // adc datapath
  input  wire logic                        sample_ready_strobe,
  input  wire logic [acr_pkg::WAV_W-1:0]   adc_result_i,
  input  wire logic [acr_pkg::WAV_W-1:0]   adc_result_v1,
  input  wire logic [acr_pkg::WAV_W-1:0]   adc_result_v2,
  // shared clock / ready pin
  input  wire logic                        clock_source_in,
  output logic                             clock_out_pin,
  // configuration outputs
  output logic                             crc_write_check_en,
  output logic                             clock_output_enable,
  output logic                             current_polarity_flip,
  output logic                             first_voltage_polarity_flip,
  output logic                             second_voltage_polarity_flip,
  output logic                             lowpass_width_select,
  output logic [2:0]                       filter_chain_select,
  output logic [1:0]                       waveform_debug_select
);
  import acr_pkg::*;

  // ==========================================================================
  // registers
  logic [DATA_W-1:0] gen_cfg_r;
  logic [DATA_W-1:0] filt_cfg_r;
  logic              soft_rst_r;
  logic              sample_pulse;
  logic              wav_hit;
  logic [ADDR_W-1:0] wav_off;
  logic [WAV_W-1:0]  wave_q [NCH];
  logic [WAV_W-1:0]  adc_in [NCH];
  acr_dbg_t          dbg_mode;

  assign adc_in[0] = adc_result_i;
  assign adc_in[1] = adc_result_v1;
  assign adc_in[2] = adc_result_v2;

  // one-cycle soft reset on key write; other values ignored
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= reg_wr && reg_addr == ADDR_SOFT_RESET
                    && reg_wdata == SOFT_RESET_KEY;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || soft_rst_r) begin
      gen_cfg_r <= GC_RESET;
    end else if (reg_wr && reg_addr == ADDR_GEN_CONFIG) begin
      gen_cfg_r <= reg_wdata & GC_WR_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || soft_rst_r) begin
      filt_cfg_r <= FC_RESET;
    end else if (reg_wr && reg_addr == ADDR_FILT_CONFIG) begin
      filt_cfg_r <= reg_wdata & FC_WR_MASK;
    end
  end

  // ==========================================================================
  // field decode
  assign dbg_mode                     = acr_dbg_t'(gen_cfg_r[GC_DBG_LSB +: 2]);
  assign waveform_debug_select        = gen_cfg_r[GC_DBG_LSB +: 2];
  assign crc_write_check_en           = gen_cfg_r[GC_CRC_BIT];
  assign clock_output_enable          = gen_cfg_r[GC_CLKO_BIT];
  assign second_voltage_polarity_flip = filt_cfg_r[FC_V2_INV_BIT];
  assign first_voltage_polarity_flip  = filt_cfg_r[FC_V1_INV_BIT];
  assign current_polarity_flip        = filt_cfg_r[FC_I_INV_BIT];
  assign lowpass_width_select         = filt_cfg_r[FC_LPF_BIT];
  assign filter_chain_select          = filt_cfg_r[FC_CHAIN_LSB +: 3];

  // ==========================================================================
  // shared pin: clock source when enabled, sample ready otherwise
  logic clk_src_sync;

  acr_sync3 u_clk_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_in    (clock_source_in),
    .level_out (clk_src_sync)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      clock_out_pin <= 1'b0;
    end else if (clock_output_enable) begin
      clock_out_pin <= clk_src_sync;
    end else begin
      clock_out_pin <= sample_ready_strobe;
    end
  end

  // ==========================================================================
  // waveform registers
  assign sample_pulse = sample_ready_strobe;
  assign wav_hit      = reg_addr >= ADDR_WAV_BASE && reg_addr <= ADDR_WAV_LAST;
  assign wav_off      = reg_addr - ADDR_WAV_BASE;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam logic [ADDR_W-1:0] CH_BASE = ADDR_W'(g * BYTES_PER_CH);
      logic            hit;
      logic [ADDR_W-1:0] sub;
      assign hit = reg_wr && wav_hit && wav_off >= CH_BASE
                   && wav_off < CH_BASE + BYTES_PER_CH;
      assign sub = wav_off - CH_BASE;
      acr_wave_chan u_chan (
        .clock        (clock),
        .rst          (rst),
        .soft_rst     (soft_rst_r),
        .dbg_mode     (dbg_mode),
        .sample_pulse (sample_pulse),
        .adc_result   (adc_in[g]),
        .wr_en        (hit),
        .wr_byte      (sub[1:0]),
        .wr_data      (reg_wdata),
        .wave_r       (wave_q[g])
      );
    end
  endgenerate

  // ==========================================================================
  // read data
  logic [DATA_W-1:0] rd_nxt;
  logic [ADDR_W-1:0] rd_ch;
  logic [ADDR_W-1:0] rd_sub;

  always_comb begin
    rd_nxt = '0;
    rd_ch  = '0;
    rd_sub = '0;
    if (reg_addr == ADDR_GEN_CONFIG) begin
      rd_nxt = gen_cfg_r;
    end else if (reg_addr == ADDR_FILT_CONFIG) begin
      rd_nxt = filt_cfg_r;
    end else if (wav_hit) begin
      rd_ch  = wav_off / BYTES_PER_CH;
      rd_sub = wav_off - rd_ch * BYTES_PER_CH;
      unique case (rd_sub[1:0])
        2'd0:    rd_nxt = wave_q[rd_ch[1:0]][2*DATA_W +: DATA_W];
        2'd1:    rd_nxt = wave_q[rd_ch[1:0]][DATA_W +: DATA_W];
        default: rd_nxt = wave_q[rd_ch[1:0]][0 +: DATA_W];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

  // ==========================================================================
  // checks
  property p_soft_reset;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_SOFT_RESET && reg_wdata == SOFT_RESET_KEY)
      |-> ##2 (gen_cfg_r == GC_RESET && filt_cfg_r == FC_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_soft_wave_clear;
    @(posedge clock) disable iff (rst)
      soft_rst_r
      |=> wave_q[0] == WAV_RESET && wave_q[1] == WAV_RESET && wave_q[2] == WAV_RESET;
  endproperty
  a_soft_wave_clear: assert property (p_soft_wave_clear) else $error("wave not cleared");

  property p_bad_key;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_SOFT_RESET && reg_wdata != SOFT_RESET_KEY)
      |=> !soft_rst_r;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key reset");

  property p_reset_read;
    @(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == ADDR_SOFT_RESET)
      |=> reg_rdata == '0;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("reset reg readable");

  property p_normal_refuse;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_NORMAL && !sample_pulse && !soft_rst_r)
      |=> $stable(wave_q[0]);
  endproperty
  a_normal_refuse: assert property (p_normal_refuse) else $error("normal wave moved");

  property p_count_write;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_COUNT && reg_wr && reg_addr == ADDR_WAV_BASE && !soft_rst_r)
      |=> wave_q[0][WAV_W-1 -: DATA_W] == $past(reg_wdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_crc_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_GEN_CONFIG && !soft_rst_r)
      |=> crc_write_check_en == $past(reg_wdata[GC_CRC_BIT]);
  endproperty
  a_crc_write: assert property (p_crc_write) else $error("crc enable wrong");

  property p_pin_clock;
    @(posedge clock) disable iff (rst)
      clock_output_enable |=> clock_out_pin == $past(clk_src_sync);
  endproperty
  a_pin_clock: assert property (p_pin_clock) else $error("pin clock wrong");

  property p_polarity;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_FILT_CONFIG && !soft_rst_r)
      |=> second_voltage_polarity_flip == $past(reg_wdata[FC_V2_INV_BIT])
          && first_voltage_polarity_flip == $past(reg_wdata[FC_V1_INV_BIT])
          && current_polarity_flip == $past(reg_wdata[FC_I_INV_BIT]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_lpf_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_FILT_CONFIG && !soft_rst_r)
      |=> lowpass_width_select == $past(reg_wdata[FC_LPF_BIT]);
  endproperty
  a_lpf_write: assert property (p_lpf_write) else $error("bandwidth wrong");

  property p_chain_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_FILT_CONFIG && !soft_rst_r)
      |=> filter_chain_select == $past(reg_wdata[FC_CHAIN_LSB +: 3]);
  endproperty
  a_chain_write: assert property (p_chain_write) else $error("chain wrong");

  property p_normal_load;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_NORMAL && sample_pulse && !soft_rst_r)
      |=> wave_q[0] == $past(adc_result_i);
  endproperty
  a_normal_load: assert property (p_normal_load) else $error("normal load wrong");

  property p_static_hold;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_STATIC && !reg_wr && !soft_rst_r) |=> $stable(wave_q[1]);
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("static changed");

  property p_count_inc;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_COUNT && sample_pulse && !reg_wr && !soft_rst_r)
      |=> wave_q[2] == $past(wave_q[2]) + WAV_STEP;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count step wrong");

  property p_rsvd_load;
    @(posedge clock) disable iff (rst)
      (dbg_mode == ACR_DBG_RSVD && sample_pulse && !soft_rst_r)
      |=> wave_q[1] == $past(adc_result_v1);
  endproperty
  a_rsvd_load: assert property (p_rsvd_load) else $error("reserved mode wrong");

  property p_crc_reset;
    @(posedge clock) $fell(rst) |-> crc_write_check_en && !clock_output_enable;
  endproperty
  a_crc_reset: assert property (p_crc_reset) else $error("config reset wrong");

  property p_pin_mux;
    @(posedge clock) disable iff (rst)
      !clock_output_enable |=> clock_out_pin == $past(sample_ready_strobe);
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin mux wrong");

  property p_filt_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == ADDR_FILT_CONFIG && !soft_rst_r)
      |=> filt_cfg_r == ($past(reg_wdata) & FC_WR_MASK) && !filt_cfg_r[7];
  endproperty
  a_filt_write: assert property (p_filt_write) else $error("filter write wrong");

  property p_gen_rsvd;
    @(posedge clock) disable iff (rst) gen_cfg_r[7:4] == 4'h0;
  endproperty
  a_gen_rsvd: assert property (p_gen_rsvd) else $error("reserved bits set");
endmodule : acr_config_bank
`default_nettype wire

/* File: include/acr_pkg.sv */
// package: register map, field layout and mode codes of the adc config bank
`default_nettype none
package acr_pkg;
  // ==========================================================================
  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WAV_W  = 24;
  localparam int unsigned NCH    = 3;

  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET  = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_GEN_CONFIG  = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_FILT_CONFIG = 8'h03;
  // waveform registers: channel c byte b (hi, md, lo) at base + 3*c + b
  localparam logic [ADDR_W-1:0] ADDR_WAV_BASE    = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_WAV_LAST    = 8'h2e;
  localparam logic [ADDR_W-1:0] BYTES_PER_CH     = 8'h03;

  localparam logic [DATA_W-1:0] SOFT_RESET_KEY   = 8'hd6;

  // ==========================================================================
  // general config fields
  localparam int unsigned GC_DBG_LSB   = 2;
  localparam int unsigned GC_CRC_BIT   = 1;
  localparam int unsigned GC_CLKO_BIT  = 0;
  localparam logic [DATA_W-1:0] GC_RESET    = 8'h02;
  localparam logic [DATA_W-1:0] GC_WR_MASK  = 8'h0f;

  // filter config fields
  localparam int unsigned FC_V2_INV_BIT = 6;
  localparam int unsigned FC_V1_INV_BIT = 5;
  localparam int unsigned FC_I_INV_BIT  = 4;
  localparam int unsigned FC_LPF_BIT    = 3;
  localparam int unsigned FC_CHAIN_LSB  = 0;
  localparam logic [DATA_W-1:0] FC_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] FC_WR_MASK  = 8'h7f;

  localparam logic [WAV_W-1:0] WAV_RESET = 24'h000000;
  localparam logic [WAV_W-1:0] WAV_STEP  = 24'h000001;

  typedef enum logic [1:0] {
    ACR_DBG_NORMAL = 2'b00,
    ACR_DBG_STATIC = 2'b01,
    ACR_DBG_COUNT  = 2'b10,
    ACR_DBG_RSVD   = 2'b11
  } acr_dbg_t;

  // low-pass bandwidth select codes
  localparam logic LOWPASS_WIDTH_SELECT_3K3 = 1'b0;
  localparam logic LOWPASS_WIDTH_SELECT_2K7 = 1'b1;
endpackage : acr_pkg
`default_nettype wire

/* File: rtl/acr_sync3.sv */
// three-stage synchroniser with agreement filter for a pin input
`default_nettype none
module acr_sync3 (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule : acr_sync3
`default_nettype wire

/* File: rtl/acr_wave_chan.sv */
// one channel waveform register with normal, static and count behaviour
`default_nettype none
module acr_wave_chan (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          soft_rst,
  // mode and events
  input  wire acr_pkg::acr_dbg_t             dbg_mode,
  input  wire logic                          sample_pulse,
  input  wire logic [acr_pkg::WAV_W-1:0]     adc_result,
  // host byte write
  input  wire logic                          wr_en,
  input  wire logic [1:0]                    wr_byte,
  input  wire logic [acr_pkg::DATA_W-1:0]    wr_data,
  // register contents
  output logic [acr_pkg::WAV_W-1:0]          wave_r
);
  import acr_pkg::*;

  logic [WAV_W-1:0] wave_nxt;
  logic             host_wr_ok;

  // host may write only in count or static mode
  assign host_wr_ok = wr_en && (dbg_mode == ACR_DBG_COUNT || dbg_mode == ACR_DBG_STATIC);

  always_comb begin
    wave_nxt = wave_r;
    unique case (dbg_mode)
      ACR_DBG_NORMAL, ACR_DBG_RSVD: begin
        if (sample_pulse) begin
          wave_nxt = adc_result;
        end
      end
      ACR_DBG_STATIC: begin
        wave_nxt = wave_r;
      end
      ACR_DBG_COUNT: begin
        if (sample_pulse) begin
          wave_nxt = wave_r + WAV_STEP;
        end
      end
    endcase
    if (host_wr_ok) begin
      unique case (wr_byte)
        2'd0:    wave_nxt[2*DATA_W +: DATA_W] = wr_data;
        2'd1:    wave_nxt[DATA_W +: DATA_W]   = wr_data;
        default: wave_nxt[0 +: DATA_W]        = wr_data;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || soft_rst) begin
      wave_r <= WAV_RESET;
    end else begin
      wave_r <= wave_nxt;
    end
  end
endmodule : acr_wave_chan
`default_nettype wire

/* File: verif/acr_host_model.sv */
// host model: register master driving the bank's register port
`default_nettype none
module acr_host_model (
  // clock
  input  wire logic       clock,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // ==========================================================================
  // bus cycles; released lines show the inverse of the last value
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
  // count mode first, then static, crc check kept on
  task go_static();
    wr(8'h02, 8'h0a);
    wr(8'h02, 8'h06);
  endtask : go_static
endmodule : acr_host_model
`default_nettype wire

/* File: verif/adc_config_register_bank_test.sv */
// testbench: scenarios for the adc configuration register bank
`default_nettype none
module adc_config_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acr_pkg::*;
  logic clock = 1'b0, rst = 1'b1, strobe = 1'b0, csrc = 1'b0;
  logic reg_wr, reg_rd, clk_pin, crc_en, clko_en, fi, f1, f2, lpf;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] chain;
  logic [1:0] dbg;
  logic [23:0] adc [3] = '{24'h0, 24'h0, 24'h0};
  int err_count = 0, checks = 0;
  always #4 clock = ~clock;
  acr_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  acr_config_bank dut (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_ready_strobe(strobe), .adc_result_i(adc[0]), .adc_result_v1(adc[1]),
    .adc_result_v2(adc[2]), .clock_source_in(csrc), .clock_out_pin(clk_pin),
    .crc_write_check_en(crc_en), .clock_output_enable(clko_en),
    .current_polarity_flip(fi), .first_voltage_polarity_flip(f1),
    .second_voltage_polarity_flip(f2), .lowpass_width_select(lpf),
    .filter_chain_select(chain), .waveform_debug_select(dbg));
  // ==========================================================================
  // helpers
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("rdata@%h", a), {16'h0, e}, {16'h0, d});
  endtask : chk_rd
  task chk_wave(input int c, input logic [23:0] e);
    for (int b = 0; b < 3; b++) chk_rd(ADDR_WAV_BASE + 8'(3 * c + b), e[8*(2-b)+:8]);
  endtask : chk_wave
  task pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      strobe = 1'b1;
      @(posedge clock);
      #1;
      strobe = 1'b0;
    end
  endtask : pulse
  task stop_test();
    $display("mismatches %0d of checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // scenarios
  task t_defaults();
    chk_rd(8'h02, 8'h02);
    chk_rd(8'h03, 8'h00);
    chk_rd(8'h01, 8'h00);
    chk("crc_en", 24'h1, {23'h0, crc_en});
    chk("dbg", 24'h0, {22'h0, dbg});
  endtask : t_defaults
  task t_fields();
    logic [7:0] v;
    host.wr(8'h02, 8'hf3);
    chk_rd(8'h02, 8'h03);
    chk("clko_en", 24'h1, {23'h0, clko_en});
    host.wr(8'h03, 8'hff);
    chk_rd(8'h03, 8'h7f);
    chk("flips", 24'h7, {21'h0, f2, f1, fi});
    for (int k = 0; k < 8; k++) begin
      v = 8'h50 | 8'(k) | 8'(k << 3);
      host.wr(8'h03, v);
      chk("fields", {16'h0, v}, {16'h0, 1'b0, f2, f1, fi, lpf, chain});
    end
    chk_rd(8'h04, 8'h00);
    host.wr(8'h02, 8'h00);
    chk("crc_off", 24'h0, {23'h0, crc_en});
  endtask : t_fields
  task t_normal(input logic [1:0] m);
    host.wr(8'h02, {4'h0, m, 2'b10});
    chk("dbg", {22'h0, m}, {22'h0, dbg});
    for (int c = 0; c < 3; c++) adc[c] = 24'h123456 + 24'(c * 24'h111111) + 24'(m);
    pulse(1);
    host.wr(8'h28, 8'haa);
    for (int c = 0; c < 3; c++) begin
      chk_wave(c, 24'h123456 + 24'(c * 24'h111111) + 24'(m));
    end
  endtask : t_normal
  task t_count_static();
    host.wr(8'h02, 8'h0a);
    chk("dbg", 24'h2, {22'h0, dbg});
    for (int c = 0; c < 3; c++) begin
      host.wr(ADDR_WAV_BASE + 8'(3 * c), 8'(c));
      host.wr(ADDR_WAV_BASE + 8'(3 * c + 1), 8'h00);
      host.wr(ADDR_WAV_BASE + 8'(3 * c + 2), 8'hfe);
    end
    pulse(3);
    for (int c = 0; c < 3; c++) chk_wave(c, {8'(c), 16'h0101});
    host.go_static();
    chk("dbg", 24'h1, {22'h0, dbg});
    adc[0] = 24'habcdef;
    pulse(2);
    chk_wave(0, 24'h000101);
    host.wr(8'h28, 8'h55);
    pulse(1);
    chk_wave(0, 24'h000155);
  endtask : t_count_static
  task t_soft_reset();
    host.wr(8'h03, 8'h2a);
    host.wr(8'h01, 8'hd5);
    chk_rd(8'h03, 8'h2a);
    host.wr(8'h01, 8'hd6);
    @(posedge clock);
    chk_rd(8'h02, 8'h02);
    chk_rd(8'h03, 8'h00);
    chk_wave(0, 24'h0);
  endtask : t_soft_reset
  task t_pin();
    pulse(1);
    chk("pin_ready", 24'h1, {23'h0, clk_pin});
    @(posedge clock);
    #1;
    chk("pin_idle", 24'h0, {23'h0, clk_pin});
    host.wr(8'h02, 8'h03);
    csrc = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk("pin_clk", 24'h1, {23'h0, clk_pin});
    csrc = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk("pin_clk", 24'h0, {23'h0, clk_pin});
  endtask : t_pin
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    t_defaults();
    t_fields();
    t_normal(2'b00);
    t_normal(2'b11);
    t_count_static();
    t_soft_reset();
    t_pin();
    stop_test();
  end
  initial begin
    #40000;
    err_count++;
    stop_test();
  end
endmodule : adc_config_register_bank_test
`default_nettype wire
